// ---- logic/field_record_pkg.sv ----
package field_record_pkg;
  // clock and reservation window
  localparam int CLK_MHZ = 250;
  localparam int RESERVE_MS = 2000;
  localparam int RESERVE_CYC = RESERVE_MS * CLK_MHZ * 1000;
  localparam int RSV_W = 29;
  // record numbers
  localparam logic [7:0] REC_REQ_FIRST = 8'd80;
  localparam logic [7:0] REC_RSP_LAST = 8'd87;
  localparam logic [7:0] REC_VARS = 8'd121;
  // apb byte addresses
  localparam logic [7:0] A_REQ = 8'h00;
  localparam logic [7:0] A_SEL = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_AUX = 8'h0C;
  localparam logic [7:0] A_CTRL = 8'h10;
  localparam logic [7:0] A_MAP = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // request word fields
  localparam int REQ_CMD_LSB = 8;
  localparam int REQ_SHC_BIT = 16;
  localparam int REQ_BURST_BIT = 17;
  // control fields
  localparam int CTRL_REV7_LSB = 4;
  localparam int CTRL_HINIT_BIT = 8;
  localparam int MAP_EN_BIT = 4;
  // processing status
  localparam logic [1:0] PS_IDLE = 2'b00;
  localparam logic [1:0] PS_BUSY = 2'b01;
  localparam logic [1:0] PS_OK = 2'b10;
  localparam logic [1:0] PS_ERR = 2'b11;
  // response codes
  localparam logic [7:0] RC_UPDATE = 8'h08;
  localparam logic [7:0] RC_ACCESS = 8'h10;
  localparam logic [7:0] RC_NOT_PROC = 8'h20;
  localparam logic [7:0] RC_BAD_REQ = 8'h40;
  // poll commands
  localparam logic [7:0] CMD_POLL_OLD = 8'h03;
  localparam logic [7:0] CMD_POLL_NEW = 8'h09;
  // status byte layout
  localparam int ST1_COMM_BIT = 7;
  localparam logic [7:0] ST2_UNCERT_MASK = 8'h97;
  // quality codes
  localparam logic [7:0] QC_GOOD = 8'h80;
  localparam logic [7:0] QC_UNCERT = 8'h78;
  localparam logic [7:0] QC_UPDATE = 8'h84;
  localparam logic [7:0] QC_ACCESS = 8'h24;
  localparam logic [7:0] QC_COMM = 8'h23;
  localparam logic [7:0] QC_MOD_INIT = 8'h37;
  localparam logic [7:0] QC_HOST_INIT = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } link_state_t;

  // uncertain bits outrank the okay group
  function automatic logic [7:0] qual_of(input logic fail, input logic [7:0] s1,
                                         input logic [7:0] s2, input logic [7:0] rc);
    if (fail || s1[ST1_COMM_BIT]) return QC_COMM;
    if (rc == RC_UPDATE) return QC_UPDATE;
    if (rc == RC_ACCESS) return QC_ACCESS;
    if (|(s2 & ST2_UNCERT_MASK)) return QC_UNCERT;
    return QC_GOOD;
  endfunction
endpackage

// ---- logic/field_request_record_handler.sv ----
`timescale 1ns/10ps
module field_request_record_handler
  import field_record_pkg::*;
#(
  parameter int RESERVE_CYCLES = RESERVE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [1:0] cmd_channel,
  output logic [7:0] cmd_code,
  output logic [1:0] cmd_var,
  output logic cmd_successive,
  input wire logic rsp_valid,
  input wire logic rsp_fail,
  input wire logic [7:0] rsp_status1,
  input wire logic [7:0] rsp_status2,
  input wire logic [7:0] rsp_code,
  input wire logic [31:0] rsp_data,
  output logic [159:0] image_data,
  output logic image_valid
);
  initial begin
    if (RESERVE_CYCLES < 2 || RESERVE_CYCLES >= 2**RSV_W) $error("bad RESERVE_CYCLES");
  end

  link_state_t state_ff;
  logic [9:0] req_ff [4];
  logic [1:0] rsp_st_ff [4];
  logic [7:0] rsp_rc_ff [4], rsp_s1_ff [4], rsp_s2_ff [4];
  logic [31:0] rsp_data_ff [4];
  logic [3:0] lock_ff, queued_ff;
  logic [11:0] rec_sel_ff;
  logic [8:0] ctrl_ff;
  logic [31:0] map_ff;
  logic [31:0] prdata_ff;
  logic slverr_ff;
  logic rsv_ff;
  logic [1:0] rsv_ch_ff;
  logic [RSV_W-1:0] rsv_cnt_ff;
  logic cur_poll_ff;
  logic [3:0] poll_idx_ff;
  logic [7:0] qual_ff [16];
  logic [31:0] mem_rdata;

  // apb decode
  logic setup, acc_wr;
  logic [7:0] wrec, woff;
  logic wrec_ok, wbad;
  logic [1:0] wch;
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & ~slverr_ff;
  assign pready = psel & penable;
  assign pslverr = psel & penable & slverr_ff;
  assign prdata = prdata_ff;
  assign wrec = pwdata[7:0];
  assign woff = wrec - REC_REQ_FIRST;
  assign wrec_ok = (wrec >= REC_REQ_FIRST) && (woff < 8'd8) && !woff[0];
  assign wch = woff[2:1];
  assign wbad = pwdata[REQ_BURST_BIT];

  logic req_take, req_bad;
  assign req_take = acc_wr && paddr == A_REQ;
  assign req_bad = req_take && wbad;

  // read multiplexer
  logic [7:0] rsel, roff;
  logic [1:0] rch;
  logic [31:0] rd_val;
  logic rd_err;
  assign rsel = rec_sel_ff[7:0];
  assign roff = rsel - REC_REQ_FIRST;
  assign rch = roff[2:1];
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    unique case (paddr)
      A_REQ: rd_val = '0;
      A_SEL: rd_val = {20'h0_0000, rec_sel_ff};
      A_DATA: begin
        if (rsel >= REC_REQ_FIRST && rsel <= REC_RSP_LAST) begin
          if (!roff[0]) rd_val = {22'h00_0000, req_ff[rch]};
          else rd_val = {6'h00, rsp_st_ff[rch], rsp_rc_ff[rch], rsp_s2_ff[rch],
                         rsp_s1_ff[rch]};
        end else if (rsel == REC_VARS) rd_val = mem_rdata;
      end
      A_AUX: begin
        if (rsel >= REC_REQ_FIRST && rsel <= REC_RSP_LAST && roff[0])
          rd_val = rsp_data_ff[rch];
        else if (rsel == REC_VARS) rd_val = {24'h00_0000, qual_ff[rec_sel_ff[11:8]]};
      end
      A_CTRL: rd_val = {23'h00_0000, ctrl_ff};
      A_MAP: rd_val = map_ff;
      A_STAT: rd_val = {23'h00_0000, !state_ff[0], 1'b0, rsv_ff, rsv_ch_ff, lock_ff};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
      slverr_ff <= rd_err || paddr == A_STAT && pwrite ||
                   pwrite && paddr == A_REQ && (!wrec_ok || lock_ff[wch]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_sel_ff <= '0;
      ctrl_ff <= '0;
      map_ff <= '0;
    end else begin
      ctrl_ff[CTRL_HINIT_BIT] <= 1'b0;
      if (acc_wr && paddr == A_SEL) rec_sel_ff <= pwdata[11:0];
      if (acc_wr && paddr == A_CTRL) ctrl_ff <= pwdata[8:0];
      if (acc_wr && paddr == A_MAP) map_ff <= pwdata;
    end
  end

  // scheduler
  logic pick_any, reject, take_client, poll_go, link_done, poll_upd;
  logic [1:0] pick_ch;
  always_comb begin
    pick_any = 1'b0;
    pick_ch = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (queued_ff[i]) begin
        pick_any = 1'b1;
        pick_ch = 2'(i);
      end
    end
  end
  assign reject = state_ff == ST_IDLE && pick_any && rsv_ff && pick_ch != rsv_ch_ff;
  assign take_client = state_ff == ST_IDLE && pick_any && !reject;
  assign poll_go = state_ff == ST_IDLE && !pick_any && !rsv_ff &&
                   ctrl_ff[poll_idx_ff[3:2]];
  assign link_done = state_ff == ST_WAIT && rsp_valid;
  assign poll_upd = link_done && cur_poll_ff && !rsv_ff;

  assign cmd_valid = state_ff == ST_SEND;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cmd_channel <= '0;
      cmd_code <= '0;
      cmd_var <= '0;
      cmd_successive <= 1'b0;
      cur_poll_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (take_client) begin
            cmd_channel <= pick_ch;
            cmd_code <= req_ff[pick_ch][7:0];
            cmd_var <= 2'd0;
            cmd_successive <= req_ff[pick_ch][8];
            cur_poll_ff <= 1'b0;
            state_ff <= ST_SEND;
          end else if (poll_go) begin
            cmd_channel <= poll_idx_ff[3:2];
            cmd_code <= ctrl_ff[CTRL_REV7_LSB + poll_idx_ff[3:2]] ?
                        CMD_POLL_NEW : CMD_POLL_OLD;
            cmd_var <= poll_idx_ff[1:0];
            cmd_successive <= 1'b0;
            cur_poll_ff <= 1'b1;
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: if (cmd_ready) state_ff <= ST_WAIT;
        ST_WAIT: if (rsp_valid) state_ff <= ST_IDLE;
      endcase
    end
  end

  // poll pointer walks channels and variables; disabled channels are stepped over
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) poll_idx_ff <= '0;
    else if (link_done && cur_poll_ff ||
             state_ff == ST_IDLE && !pick_any && !rsv_ff && !poll_go)
      poll_idx_ff <= poll_idx_ff + 4'd1;
  end

  // request records, locks and responses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= '0;
      queued_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        req_ff[i] <= '0;
        rsp_st_ff[i] <= PS_IDLE;
        rsp_rc_ff[i] <= '0;
        rsp_s1_ff[i] <= '0;
        rsp_s2_ff[i] <= '0;
        rsp_data_ff[i] <= '0;
      end
    end else begin
      if (reject) begin
        lock_ff[pick_ch] <= 1'b0;
        queued_ff[pick_ch] <= 1'b0;
        rsp_st_ff[pick_ch] <= PS_ERR;
        rsp_rc_ff[pick_ch] <= RC_NOT_PROC;
      end
      if (take_client) begin
        queued_ff[pick_ch] <= 1'b0;
        rsp_st_ff[pick_ch] <= PS_BUSY;
      end
      if (link_done && !cur_poll_ff) begin
        lock_ff[cmd_channel] <= 1'b0;
        rsp_st_ff[cmd_channel] <= (rsp_fail || rsp_status1[ST1_COMM_BIT]) ? PS_ERR : PS_OK;
        rsp_rc_ff[cmd_channel] <= rsp_code;
        rsp_s1_ff[cmd_channel] <= rsp_status1;
        rsp_s2_ff[cmd_channel] <= rsp_status2;
        rsp_data_ff[cmd_channel] <= rsp_data;
      end
      // locked records refuse writes, so a new lock never meets its own clear
      if (req_take) begin
        req_ff[wch] <= pwdata[REQ_BURST_BIT:REQ_CMD_LSB];
        rsp_data_ff[wch] <= '0;
        if (req_bad) begin
          rsp_st_ff[wch] <= PS_ERR;
          rsp_rc_ff[wch] <= RC_BAD_REQ;
        end else begin
          lock_ff[wch] <= 1'b1;
          queued_ff[wch] <= 1'b1;
          rsp_st_ff[wch] <= PS_BUSY;
          rsp_rc_ff[wch] <= '0;
        end
      end
    end
  end

  // successive command reservation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsv_ff <= 1'b0;
      rsv_ch_ff <= '0;
      rsv_cnt_ff <= '0;
    end else if (take_client && req_ff[pick_ch][8]) begin
      rsv_ff <= 1'b1;
      rsv_ch_ff <= pick_ch;
      rsv_cnt_ff <= RSV_W'(RESERVE_CYCLES - 1);
    end else if (take_client && rsv_ff) begin
      rsv_ff <= 1'b0;
    end else if (rsv_ff) begin
      if (rsv_cnt_ff == '0) rsv_ff <= 1'b0;
      else rsv_cnt_ff <= rsv_cnt_ff - 1'b1;
    end
  end

  // polled variables, quality and input image
  logic [7:0] new_qual;
  assign new_qual = qual_of(rsp_fail, rsp_status1, rsp_status2, rsp_code);

  var_store #(.DW(32), .DEPTH(16)) u_vars (
    .ref_clk(ref_clk),
    .we(poll_upd),
    .waddr({cmd_channel, cmd_var}),
    .wdata(rsp_data),
    .raddr(rec_sel_ff[11:8]),
    .rdata(mem_rdata)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) qual_ff[i] <= QC_MOD_INIT;
    end else if (ctrl_ff[CTRL_HINIT_BIT]) begin
      for (int i = 0; i < 16; i++) qual_ff[i] <= QC_HOST_INIT;
    end else if (poll_upd) begin
      qual_ff[{cmd_channel, cmd_var}] <= new_qual;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 4; s++) image_data[s*40 +: 40] <= {QC_MOD_INIT, 32'h0000_0000};
    end else begin
      for (int s = 0; s < 4; s++) begin
        if (ctrl_ff[CTRL_HINIT_BIT]) image_data[s*40+32 +: 8] <= QC_HOST_INIT;
        else if (poll_upd && map_ff[s*8+MAP_EN_BIT] &&
                 map_ff[s*8 +: 4] == {cmd_channel, cmd_var})
          image_data[s*40 +: 40] <= {new_qual, rsp_data};
      end
    end
  end

  // the whole 20 byte image stands whenever any slot is mapped
  assign image_valid = |{map_ff[24+MAP_EN_BIT], map_ff[16+MAP_EN_BIT],
                         map_ff[8+MAP_EN_BIT], map_ff[MAP_EN_BIT]};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_LOCK_BUSY: assert property (
    setup && pwrite && paddr == A_REQ && wrec_ok && lock_ff[wch] |=> pslverr)
    else $error("write to locked request record not refused");
  AST_UNLOCK: assert property (
    link_done && !cur_poll_ff |=> !lock_ff[$past(cmd_channel)] && !state_ff[2])
    else $error("request lock not released on completion");
  AST_NO_POLL_RSV: assert property (
    cmd_valid && cur_poll_ff |-> !rsv_ff)
    else $error("poll issued during reservation");
  AST_RSV_RESTART: assert property (
    take_client && req_ff[pick_ch][8] |=> rsv_ff && rsv_cnt_ff == RSV_W'(RESERVE_CYCLES - 1))
    else $error("reservation not restarted");
  AST_RSV_EXPIRE: assert property (
    rsv_ff && rsv_cnt_ff == '0 && !take_client |=> !rsv_ff)
    else $error("reservation outlived its window");
  AST_POLL_CODE: assert property (
    poll_go && !(acc_wr && paddr == A_CTRL) |=>
      cmd_code == (ctrl_ff[CTRL_REV7_LSB + cmd_channel] ? CMD_POLL_NEW : CMD_POLL_OLD))
    else $error("wrong poll command");
  AST_OVERWRITE: assert property (
    req_take && !wbad |=> rsp_st_ff[$past(wch)] == PS_BUSY && lock_ff[$past(wch)])
    else $error("pending response not overwritten");
  AST_BAD_REQ: assert property (
    req_bad |=> rsp_st_ff[$past(wch)] == PS_ERR && !lock_ff[$past(wch)])
    else $error("faulty request not reported");
  AST_QUAL: assert property (
    poll_upd && !ctrl_ff[CTRL_HINIT_BIT] && !rsp_fail && !rsp_status1[ST1_COMM_BIT]
      && rsp_code == 8'h00 && |(rsp_status2 & ST2_UNCERT_MASK)
      |=> qual_ff[$past({cmd_channel, cmd_var})] == QC_UNCERT)
    else $error("uncertain quality not reported");
  AST_FREEZE: assert property (
    rsv_ff && !ctrl_ff[CTRL_HINIT_BIT] |=> $stable(image_data))
    else $error("image changed during reservation");

  COV_CLIENT: cover property (take_client ##[1:20] link_done);
  COV_REJECT: cover property (reject);
  COV_POLL_UPD: cover property (poll_upd);
  COV_BUSY: cover property (pslverr && pready);
endmodule // field_request_record_handler

// ---- logic/var_store.sv ----
`timescale 1ns/10ps
module var_store #(
  parameter int DW = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("var_store depth too small");
  end

  always_ff @(posedge ref_clk) begin
    if (we) mem[waddr] <= wdata;
  end

  always_ff @(posedge ref_clk) begin
    rdata <= mem[raddr];
  end
endmodule // var_store

// ---- testbench/field_link_model.sv ----
`timescale 1ns/10ps
module field_link_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_channel,
  input wire logic [7:0] cmd_code,
  input wire logic [1:0] cmd_var,
  input wire logic [3:0] lat,
  input wire logic fail,
  input wire logic [7:0] st1,
  input wire logic [7:0] st2,
  input wire logic [7:0] rc,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_fail,
  output logic [7:0] rsp_status1,
  output logic [7:0] rsp_status2,
  output logic [7:0] rsp_code,
  output logic [31:0] rsp_data
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  logic [15:0] seq_ff;
  logic [15:0] tag_ff;
  logic [56:0] word;
  // seq changes every answer so a frozen image is visible
  assign word = {fail, st1, st2, rc, seq_ff, tag_ff};
  // lines only carry the answer during the pulse, the inverse elsewhere
  assign {rsp_fail, rsp_status1, rsp_status2, rsp_code, rsp_data} = rsp_valid ? word : ~word;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      seq_ff <= 16'h0000;
      tag_ff <= 16'h0000;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      if (!busy_ff && cmd_valid && !cmd_ready) begin
        if (cnt_ff >= lat) begin
          cmd_ready <= 1'b1;
          busy_ff <= 1'b1;
          cnt_ff <= 4'h0;
          tag_ff <= {2'b00, cmd_channel, 2'b00, cmd_var, cmd_code};
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else if (busy_ff) begin
        // one answer for each command taken
        if (cnt_ff >= lat) begin
          rsp_valid <= 1'b1;
          busy_ff <= 1'b0;
          cnt_ff <= 4'h0;
          seq_ff <= seq_ff + 16'h0001;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
endmodule // field_link_model

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import field_record_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_valid, cmd_ready, cmd_successive, rsp_valid, rsp_fail, image_valid;
  logic [1:0] cmd_channel, cmd_var;
  logic [7:0] cmd_code, rsp_status1, rsp_status2, rsp_code;
  logic [31:0] rsp_data;
  logic [159:0] image_data;
  logic [3:0] lat = 4'h0;
  logic m_fail = 1'b0;
  logic [7:0] m_st1 = 8'h00;
  logic [7:0] m_st2 = 8'h00;
  logic [7:0] m_rc = 8'h00;
  logic [1:0] last_ch;
  logic last_shc;
  logic [7:0] poll_code;
  logic [31:0] rd;
  logic er;
  logic [39:0] img;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int polls = 0;
  int n;
  // fail, status1, status2, code, expected quality
  localparam logic [32:0] QT [12] = '{
    {1'b0, 8'h00, 8'h40, 8'h00, 8'h80}, {1'b0, 8'h00, 8'h20, 8'h00, 8'h80},
    {1'b0, 8'h00, 8'h08, 8'h00, 8'h80}, {1'b0, 8'h00, 8'h10, 8'h00, 8'h78},
    {1'b0, 8'h00, 8'h04, 8'h00, 8'h78}, {1'b0, 8'h00, 8'h02, 8'h00, 8'h78},
    {1'b0, 8'h00, 8'h01, 8'h00, 8'h78}, {1'b0, 8'h00, 8'h44, 8'h00, 8'h78},
    {1'b0, 8'h00, 8'h00, 8'h08, 8'h84}, {1'b0, 8'h00, 8'h00, 8'h10, 8'h24},
    {1'b1, 8'h00, 8'h00, 8'h00, 8'h23}, {1'b0, 8'h80, 8'h00, 8'h00, 8'h23}};

  always #2 ref_clk = ~ref_clk;

  field_request_record_handler #(.RESERVE_CYCLES(50)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_channel(cmd_channel), .cmd_code(cmd_code), .cmd_var(cmd_var),
    .cmd_successive(cmd_successive), .rsp_valid(rsp_valid), .rsp_fail(rsp_fail),
    .rsp_status1(rsp_status1), .rsp_status2(rsp_status2), .rsp_code(rsp_code),
    .rsp_data(rsp_data), .image_data(image_data), .image_valid(image_valid));

  field_link_model i_link (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_channel(cmd_channel), .cmd_code(cmd_code), .cmd_var(cmd_var), .lat(lat),
    .fail(m_fail), .st1(m_st1), .st2(m_st2), .rc(m_rc), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .rsp_status1(rsp_status1),
    .rsp_status2(rsp_status2), .rsp_code(rsp_code), .rsp_data(rsp_data));

  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      if (cmd_code === CMD_POLL_OLD || cmd_code === CMD_POLL_NEW) begin
        polls <= polls + 1;
        poll_code <= cmd_code;
      end else begin
        last_ch <= cmd_channel;
        last_shc <= cmd_successive;
      end
    end
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // a single client per channel; each request is answered before the next
  task automatic rsp(input int c);
    apb(1'b1, A_SEL, 32'(81 + 2 * c));
    repeat (40) begin
      apb(1'b0, A_DATA, 32'h0000_0000);
      if (rd[25:24] === PS_OK || rd[25:24] === PS_ERR) break;
    end
  endtask

  // a fresh poll answer changes the value, so an old quality cannot pass for a new one
  task automatic wait_q(input logic [7:0] q);
    logic [31:0] v;
    v = image_data[31:0];
    repeat (300) begin
      @(posedge ref_clk);
      if (image_data[31:0] !== v && image_data[39:32] === q) break;
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    check(32'(image_data[39:32]), 32'(QC_MOD_INIT));
    check(32'(image_valid), 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    apb(1'b1, A_STAT, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    apb(1'b0, A_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    lat <= 4'h3;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_REQ, {16'h0000, 8'(8'h10 + c), 8'(REC_REQ_FIRST + 2 * c)});
      if (c == 0) begin
        apb(1'b1, A_REQ, {16'h0000, 8'h77, REC_REQ_FIRST});
        check(32'(er), 32'h0000_0001);
        apb(1'b0, A_STAT, 32'h0000_0000);
        check(32'(rd[3:0]), 32'h0000_0001);
      end
      rsp(c);
      check(32'(rd[25:16]), {22'h0, PS_OK, 8'h00});
      apb(1'b0, A_AUX, 32'h0000_0000);
      check(32'(rd[7:0]), 32'(8'h10 + c));
      check(32'(last_ch), 32'(c));
    end
    apb(1'b0, A_STAT, 32'h0000_0000);
    check(32'(rd[3:0]), 32'h0000_0000);
    apb(1'b1, A_REQ, {16'h0000, 8'h02, 8'd80});
    repeat (30) @(posedge ref_clk);
    apb(1'b1, A_REQ, {16'h0000, 8'h05, 8'd80});
    rsp(0);
    apb(1'b0, A_AUX, 32'h0000_0000);
    check(32'(rd[7:0]), 32'h0000_0005);
    apb(1'b1, A_REQ, {16'h0000, 8'h01, 8'd81});
    check(32'(er), 32'h0000_0001);
    apb(1'b1, A_REQ, {14'h0000, 2'b10, 8'h07, 8'd82});
    rsp(1);
    check(32'(rd[25:16]), {22'h0, PS_ERR, RC_BAD_REQ});
    apb(1'b1, A_SEL, 32'd82);
    apb(1'b0, A_DATA, 32'h0000_0000);
    check(32'(rd[9:0]), 32'h0000_0207);
    // polling of channel 1 only, slot 0 shows its first variable
    lat <= 4'h0;
    apb(1'b1, A_MAP, 32'h0000_0014);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    check(32'(image_valid), 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      {m_fail, m_st1, m_st2, m_rc} <= QT[i][32:8];
      wait_q(QT[i][7:0]);
      check(32'(image_data[39:32]), 32'(QT[i][7:0]));
    end
    {m_fail, m_st1, m_st2, m_rc} <= 25'h000_0000;
    wait_q(QC_GOOD);
    check(32'(image_data[15:0]), 32'h0000_1003);
    check(32'(poll_code), 32'(CMD_POLL_OLD));
    apb(1'b1, A_SEL, 32'h0000_0479);
    apb(1'b0, A_DATA, 32'h0000_0000);
    check(32'(rd[15:0]), 32'h0000_1003);
    apb(1'b0, A_AUX, 32'h0000_0000);
    check(32'(rd[7:0]), 32'(QC_GOOD));
    apb(1'b1, A_CTRL, 32'h0000_0022);
    repeat (40) @(posedge ref_clk);
    check(32'(poll_code), 32'(CMD_POLL_NEW));
    // second flagged command lands before the first window would run out
    apb(1'b1, A_REQ, {15'h0000, 1'b1, 8'h01, 8'd82});
    rsp(1);
    check(32'(last_shc), 32'h0000_0001);
    n = polls;
    img = image_data[39:0];
    repeat (25) @(posedge ref_clk);
    apb(1'b1, A_REQ, {15'h0000, 1'b1, 8'h01, 8'd82});
    rsp(1);
    apb(1'b1, A_REQ, {16'h0000, 8'h01, 8'd84});
    rsp(2);
    check(32'(rd[25:16]), {22'h0, PS_ERR, RC_NOT_PROC});
    apb(1'b0, A_STAT, 32'h0000_0000);
    check(32'(rd[6:4]), 32'h0000_0005);
    check(32'(polls), 32'(n));
    check(image_data[31:0], img[31:0]);
    check(32'(image_data[39:32]), 32'(img[39:32]));
    repeat (80) @(posedge ref_clk);
    check(32'(polls > n), 32'h0000_0001);
    // stop polling first so an answer in flight cannot overwrite the init code
    apb(1'b1, A_CTRL, 32'h0000_0000);
    repeat (10) @(posedge ref_clk);
    apb(1'b1, A_CTRL, 32'h0000_0100);
    repeat (3) @(posedge ref_clk);
    check(32'(image_data[39:32]), 32'(QC_HOST_INIT));
    conclude();
  end
endmodule // testbench
